// [inc/adb_pkg.sv]
/*
 * constants for the address decoder, bit-band alias and external memory port.
 * assumes a single bus clock at 40 MHz and a synchronous active-high reset.
 */
// Summary of operation
// [R1] external access lasts exactly four bus cycles
// [R2] one external memory kind configured at once
// [R3] at most 24 address bits, external region
// [R4] external data bus 8 or 16 bits
// [R5] fetch from external only when 16 bits
// [R6] alias write sets/clears one SRAM bit
// [R7] alias read returns mapped bit in bit0
// [R8] alias 0x22000000 mirrors 1 MB at 0x20000000
// [R9] unaligned word and half-word accesses accepted
// [R10] code buses only reach code range
// [R11] system bus reaches SRAM, peripherals, external, upper
// [R12] system bus fetches allowed in SRAM region
// [R13] system control via private peripheral bus
// [R14] code region is lowest 0.5 GB
// [R15] one target select, external gets low bits
package adb_pkg;
    localparam logic [31:0] CODE_TOP      = 32'h1FFFFFFF;
    localparam logic [31:0] SRAM_BASE     = 32'h20000000;
    localparam logic [31:0] SRAM_TOP      = 32'h3FFFFFFF;
    localparam logic [31:0] BB_BASE       = 32'h20000000;
    localparam logic [31:0] BB_TOP        = 32'h200FFFFF;
    localparam logic [31:0] ALIAS_BASE    = 32'h22000000;
    localparam logic [31:0] ALIAS_TOP     = 32'h23FFFFFF;
    localparam logic [31:0] PERI_BASE     = 32'h40000000;
    localparam logic [31:0] PERI_TOP      = 32'h5FFFFFFF;
    localparam logic [31:0] XRAM_BASE     = 32'h60000000;
    localparam logic [31:0] XRAM_TOP      = 32'h9FFFFFFF;
    localparam logic [31:0] XPER_BASE     = 32'hA0000000;
    localparam logic [31:0] XPER_TOP      = 32'hDFFFFFFF;
    localparam logic [31:0] PRIV_BASE     = 32'hE0000000;
    localparam logic [31:0] PRIV_TOP      = 32'hE00FFFFF;
    localparam logic [31:0] UPPER_BASE    = 32'hE0100000;
    localparam int          XADDR_W       = 24;
    localparam int          XMEM_CYCLES   = 4;
    localparam logic [2:0]  XMEM_LAST     = 3'h3;
    localparam int          CLK_MHZ       = 40;
    typedef enum logic [7:0] {
        ADB_TGT_NONE = 8'h01,
        ADB_TGT_CODE = 8'h02,
        ADB_TGT_SRAM = 8'h04,
        ADB_TGT_PERI = 8'h08,
        ADB_TGT_XMEM = 8'h10,
        ADB_TGT_XPER = 8'h20,
        ADB_TGT_PRIV = 8'h40,
        ADB_TGT_UPPR = 8'h80
    } adb_tgt_t;
    typedef enum logic [3:0] {
        ADB_ST_IDLE = 4'h1,
        ADB_ST_XMEM = 4'h2,
        ADB_ST_BBRD = 4'h4,
        ADB_ST_BBWR = 4'h8
    } adb_state_t;
endpackage

// [src/adb_fabric.sv]
/*
 * address decoder, bus selection, bit-band alias and external memory window.
 * assumes the core buses hold a request until ready_o; single bus clock domain.
 */
`timescale 1ns/1ps
module adb_fabric (
    // clock and reset
    input  wire logic                      sys_clk_i,
    input  wire logic                      rst_i,
    // static configuration
    input  wire logic                      xmem_wide_i,
    input  wire logic                      xmem_sync_i,
    // upstream request: bus select 0 code-instr, 1 code-data, 2 system, 3 private
    input  wire logic                      req_i,
    input  wire logic [1:0]                bus_sel_i,
    input  wire logic                      fetch_i,
    input  wire logic                      we_i,
    input  wire logic [1:0]                size_i,
    input  wire logic [31:0]               addr_i,
    input  wire logic [31:0]               wdata_i,
    output logic                           ready_o,
    output logic                           err_o,
    output logic [31:0]                    rdata_o,
    // downstream target selects and shared signals
    output adb_pkg::adb_tgt_t              tgt_o,
    output logic                           tgt_req_o,
    output logic                           tgt_we_o,
    output logic [31:0]                    tgt_addr_o,
    output logic [31:0]                    tgt_wdata_o,
    output logic [3:0]                     tgt_be_o,
    input  wire logic                      tgt_ready_i,
    input  wire logic [31:0]               tgt_rdata_i,
    // sram port used by the bit-band engine
    output logic                           bb_req_o,
    output logic                           bb_we_o,
    output logic [31:0]                    bb_addr_o,
    output logic [31:0]                    bb_wdata_o,
    input  wire logic                      bb_ready_i,
    input  wire logic [31:0]               bb_rdata_i,
    // external memory pins
    output logic [adb_pkg::XADDR_W-1:0]    xaddr_o,
    output logic [15:0]                    xdata_o,
    output logic [15:0]                    xdata_oe_n_o,
    input  wire logic [15:0]               xdata_i,
    output logic                           xcs_o,
    output logic                           xwe_o,
    output logic                           xoe_o,
    output logic                           xsync_o
);
    import adb_pkg::*;

    adb_state_t  st_r;
    adb_tgt_t    tgt_nxt;
    logic        alias_hit;
    logic        legal;
    logic [31:0] bb_word_addr;
    logic [4:0]  bb_bit;
    logic        x_req;
    logic        x_done;
    logic [15:0] x_rdata;
    logic [3:0]  be_nxt;
    logic        bb_phase_r;
    logic [31:0] bb_hold_r;

    // region decode: exactly one select per access
    always_comb begin
        tgt_nxt = ADB_TGT_NONE;
        if (addr_i <= CODE_TOP) begin
            tgt_nxt = ADB_TGT_CODE; // [R14]
        end else if (addr_i <= SRAM_TOP) begin
            tgt_nxt = ADB_TGT_SRAM;
        end else if (addr_i <= PERI_TOP) begin
            tgt_nxt = ADB_TGT_PERI;
        end else if (addr_i <= XRAM_TOP) begin
            tgt_nxt = ADB_TGT_XMEM; // [R3]
        end else if (addr_i <= XPER_TOP) begin
            tgt_nxt = ADB_TGT_XPER;
        end else if (addr_i <= PRIV_TOP) begin
            tgt_nxt = ADB_TGT_PRIV;
        end else begin
            tgt_nxt = ADB_TGT_UPPR;
        end
    end

    // bus legality per region
    always_comb begin
        legal = 1'b0;
        if (bus_sel_i == 2'h0 || bus_sel_i == 2'h1) begin
            legal = (tgt_nxt == ADB_TGT_CODE); // [R10]
        end else if (bus_sel_i == 2'h2) begin
            if (fetch_i)
                legal = (tgt_nxt == ADB_TGT_SRAM) || // [R12]
                        (tgt_nxt == ADB_TGT_XMEM && xmem_wide_i); // [R5]
            else
                legal = (tgt_nxt != ADB_TGT_CODE) && (tgt_nxt != ADB_TGT_PRIV); // [R11]
        end else begin
            legal = (tgt_nxt == ADB_TGT_PRIV); // [R13]
        end
    end

    // alias word n maps to sram bit n: 4 bytes per bit
    assign alias_hit    = (addr_i >= ALIAS_BASE) && (addr_i <= ALIAS_TOP); // [R8]
    assign bb_word_addr = BB_BASE + {12'h000, addr_i[24:7], 2'b00}; // [R8]
    assign bb_bit       = addr_i[6:2];

    // byte enables; unaligned accesses pass with only the lanes they touch inside the addressed word
    always_comb begin
        be_nxt = 4'hF;
        if (size_i == 2'h0)
            be_nxt = 4'h1 << addr_i[1:0];
        else if (size_i == 2'h1)
            be_nxt = (addr_i[1:0] == 2'h3) ? 4'h8 : (4'h3 << addr_i[1:0]); // [R9]
        else
            be_nxt = 4'hF << addr_i[1:0]; // [R9]
    end

    // request state machine
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_r <= ADB_ST_IDLE;
        end else begin
            case (st_r)
                ADB_ST_IDLE: begin
                    if (req_i && legal && tgt_nxt == ADB_TGT_XMEM)
                        st_r <= ADB_ST_XMEM;
                    else if (req_i && legal && alias_hit)
                        st_r <= we_i ? ADB_ST_BBWR : ADB_ST_BBRD;
                end
                ADB_ST_XMEM: begin
                    if (x_done) st_r <= ADB_ST_IDLE;
                end
                ADB_ST_BBRD: begin
                    if (bb_ready_i) st_r <= ADB_ST_IDLE;
                end
                ADB_ST_BBWR: begin
                    if (bb_ready_i && bb_phase_r) st_r <= ADB_ST_IDLE;
                end
                default: st_r <= ADB_ST_IDLE;
            endcase
        end
    end

    // bit-band read-modify-write: read phase then write phase, not interruptible
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            bb_phase_r <= 1'b0;
            bb_hold_r  <= 32'h00000000;
        end else if (st_r == ADB_ST_BBWR && bb_ready_i && !bb_phase_r) begin
            bb_phase_r <= 1'b1;
            bb_hold_r  <= wdata_i[0] ? (bb_rdata_i | (32'h00000001 << bb_bit))
                                     : (bb_rdata_i & ~(32'h00000001 << bb_bit)); // [R6]
        end else if (st_r != ADB_ST_BBWR) begin
            bb_phase_r <= 1'b0;
        end
    end

    assign bb_req_o   = (st_r == ADB_ST_BBRD) || (st_r == ADB_ST_BBWR);
    assign bb_we_o    = (st_r == ADB_ST_BBWR) && bb_phase_r;
    assign bb_addr_o  = bb_word_addr;
    assign bb_wdata_o = bb_hold_r;

    // plain targets pass straight through; external window gets low bits only
    assign tgt_o       = (req_i && legal && !alias_hit && tgt_nxt != ADB_TGT_XMEM) ? tgt_nxt : ADB_TGT_NONE; // [R15]
    assign tgt_req_o   = (st_r == ADB_ST_IDLE) && (tgt_o != ADB_TGT_NONE);
    assign tgt_we_o    = we_i;
    assign tgt_addr_o  = addr_i;
    assign tgt_wdata_o = wdata_i;
    assign tgt_be_o    = be_nxt;
    assign x_req       = (st_r == ADB_ST_IDLE) && req_i && legal && (tgt_nxt == ADB_TGT_XMEM);

    // one memory kind at a time: a single static sync/async strap
    assign xsync_o = xmem_sync_i; // [R2]

    adb_xmem_port #(
        .ADDR_W (XADDR_W)
    ) u_xmem (
        .sys_clk_i    (sys_clk_i),
        .rst_i        (rst_i),
        .req_i        (x_req),
        .we_i         (we_i),
        .addr_i       (addr_i[XADDR_W-1:0]), // [R15]
        .wdata_i      (wdata_i[15:0]),
        .wide_i       (xmem_wide_i),
        .done_o       (x_done),
        .rdata_o      (x_rdata),
        .xaddr_o      (xaddr_o),
        .xdata_o      (xdata_o),
        .xdata_oe_n_o (xdata_oe_n_o),
        .xdata_i      (xdata_i),
        .xcs_o        (xcs_o),
        .xwe_o        (xwe_o),
        .xoe_o        (xoe_o)
    );

    // response mux: illegal bus/region answers at once with an error
    always_comb begin
        ready_o = 1'b0;
        err_o   = 1'b0;
        rdata_o = 32'h00000000;
        if (st_r == ADB_ST_IDLE && req_i && !legal) begin
            ready_o = 1'b1;
            err_o   = 1'b1;
        end else if (st_r == ADB_ST_XMEM) begin
            ready_o = x_done;
            rdata_o = {16'h0000, x_rdata};
        end else if (st_r == ADB_ST_BBRD) begin
            ready_o = bb_ready_i;
            rdata_o = {31'h00000000, bb_rdata_i[bb_bit]}; // [R7]
        end else if (st_r == ADB_ST_BBWR) begin
            ready_o = bb_ready_i && bb_phase_r;
        end else if (tgt_req_o) begin
            ready_o = tgt_ready_i;
            rdata_o = tgt_rdata_i;
        end
    end

    a_code_bus_only: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (req_i && bus_sel_i[1] == 1'b0 && addr_i > CODE_TOP && st_r == ADB_ST_IDLE) |-> err_o) // [R10]
        else $error("code bus reached outside code range");
    a_priv_no_sys: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (req_i && bus_sel_i == 2'h2 && tgt_nxt == ADB_TGT_PRIV && st_r == ADB_ST_IDLE) |-> err_o) // [R13]
        else $error("system bus reached private registers");
    a_narrow_nofetch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (st_r == ADB_ST_IDLE && req_i && fetch_i && tgt_nxt == ADB_TGT_XMEM && !xmem_wide_i) |-> !x_req) // [R5]
        else $error("fetch from narrow external memory");
    a_sys_sram_fetch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (st_r == ADB_ST_IDLE && req_i && bus_sel_i == 2'h2 && fetch_i && tgt_nxt == ADB_TGT_SRAM) |-> !err_o) // [R12]
        else $error("system fetch in sram refused");
    a_sys_data_ok: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (st_r == ADB_ST_IDLE && req_i && bus_sel_i == 2'h2 && !fetch_i && addr_i >= UPPER_BASE) |-> !err_o) // [R11]
        else $error("system data access to upper range refused");
    a_bb_set_bit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (bb_we_o && bb_ready_i) |-> (bb_wdata_o[bb_bit] == wdata_i[0])) // [R6]
        else $error("alias write did not place bit");
    a_bb_read_bit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (st_r == ADB_ST_BBRD && bb_ready_i) |-> (rdata_o == {31'h00000000, bb_rdata_i[bb_bit]})) // [R7]
        else $error("alias read wrong");
    a_bb_map_addr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        bb_req_o |-> (bb_addr_o >= BB_BASE && bb_addr_o <= BB_TOP && bb_addr_o[1:0] == 2'b00)) // [R8]
        else $error("alias mapped outside bit-band sram");
    a_one_select: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $onehot(tgt_o) && !(tgt_req_o && x_req)) // [R15]
        else $error("more than one target selected");
    a_xmem_sync_st: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        xcs_o |-> $stable(xsync_o)) // [R2]
        else $error("memory kind changed during access");
    a_unaligned_ok: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (st_r == ADB_ST_IDLE && req_i && legal && size_i != 2'h0 && addr_i[1:0] != 2'h0) |-> !err_o) // [R9]
        else $error("unaligned access refused");
    a_code_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (tgt_o == ADB_TGT_CODE) |-> (addr_i <= CODE_TOP)) // [R14]
        else $error("code select above code region");
    a_xaddr_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        x_req |=> (xaddr_o == $past(addr_i[XADDR_W-1:0]))) // [R3]
        else $error("external address not low bits");

    c_xmem_read: cover property (@(posedge sys_clk_i) disable iff (rst_i) x_req && !we_i ##4 x_done);
    c_bb_write:  cover property (@(posedge sys_clk_i) disable iff (rst_i) st_r == ADB_ST_BBWR ##[1:8] st_r == ADB_ST_IDLE);
    c_bb_read:   cover property (@(posedge sys_clk_i) disable iff (rst_i) st_r == ADB_ST_BBRD && bb_ready_i);
    c_bus_error: cover property (@(posedge sys_clk_i) disable iff (rst_i) err_o);
endmodule

// [src/adb_xmem_port.sv]
/*
 * external memory port: fixed four-cycle access sequencer.
 * assumes requests come from the decoder on the same clock, one at a time.
 */
`timescale 1ns/1ps
module adb_xmem_port #(
    parameter int ADDR_W = 24
) (
    // clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    // request from decoder
    input  wire logic              req_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [15:0]       wdata_i,
    input  wire logic              wide_i,
    output logic                   done_o,
    output logic [15:0]            rdata_o,
    // external memory pins
    output logic [ADDR_W-1:0]      xaddr_o,
    output logic [15:0]            xdata_o,
    output logic [15:0]            xdata_oe_n_o,
    input  wire logic [15:0]       xdata_i,
    output logic                   xcs_o,
    output logic                   xwe_o,
    output logic                   xoe_o
);
    import adb_pkg::*;

    // elaboration check: the port never drives more pins than the external window allows
    if (ADDR_W < 1 || ADDR_W > XADDR_W) begin : g_bad_width
        $error("external address width out of range");
    end

    logic [2:0]  cnt_r;
    logic        busy_r;
    logic [15:0] xd_s1_r;
    logic [15:0] xd_s2_r;

    // access counter: every access spans exactly four bus cycles
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
            cnt_r  <= 3'h0;
        end else if (!busy_r && req_i) begin
            busy_r <= 1'b1; // [R1]
            cnt_r  <= 3'h0;
        end else if (busy_r) begin
            cnt_r  <= cnt_r + 3'h1;
            if (cnt_r == XMEM_LAST) busy_r <= 1'b0; // [R1]
        end
    end

    // pin drive, held for the whole access
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            xaddr_o      <= '0;
            xdata_o      <= 16'h0000;
            xdata_oe_n_o <= 16'hFFFF;
            xcs_o        <= 1'b0;
            xwe_o        <= 1'b0;
            xoe_o        <= 1'b0;
        end else if (!busy_r && req_i) begin
            xaddr_o      <= addr_i; // [R3]
            xdata_o      <= wide_i ? wdata_i : {8'h00, wdata_i[7:0]}; // [R4]
            xdata_oe_n_o <= we_i ? (wide_i ? 16'h0000 : 16'hFF00) : 16'hFFFF;
            xcs_o        <= 1'b1;
            xwe_o        <= we_i;
            xoe_o        <= !we_i;
        end else if (busy_r && cnt_r == XMEM_LAST) begin
            xdata_oe_n_o <= 16'hFFFF;
            xcs_o        <= 1'b0;
            xwe_o        <= 1'b0;
            xoe_o        <= 1'b0;
        end
    end

    // read data pins cross from the outside world: two stages
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            xd_s1_r <= 16'h0000;
            xd_s2_r <= 16'h0000;
            rdata_o <= 16'h0000;
        end else begin
            xd_s1_r <= xdata_i;
            xd_s2_r <= xd_s1_r;
            // captured one cycle early so the word already stands while done_o is high
            if (busy_r && cnt_r == XMEM_LAST - 3'h1)
                rdata_o <= wide_i ? xd_s2_r : {8'h00, xd_s2_r[7:0]}; // [R4]
        end
    end

    assign done_o = busy_r && (cnt_r == XMEM_LAST);

    a_xmem_four_cyc: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!busy_r && req_i) |=> xcs_o [*4] ##1 !xcs_o) // [R1]
        else $error("external access not four cycles");
    a_xmem_done_pos: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!busy_r && req_i) |-> ##4 done_o) // [R1]
        else $error("external done not at fourth cycle");
endmodule

// [verification/adb_fabric_tb_top.sv]
/*
 * self-checking bench for the fabric: decode, alias and external port.
 * assumes the far-side model below and one 40 MHz clock.
 */
`timescale 1ns/1ps
module adb_fabric_tb_top;
    import adb_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, wide = 1'b1, sync = 1'b0;
    logic        req = 1'b0, fetch = 1'b0, we = 1'b0, ready, err, tgt_req, tgt_we, tgt_ready;
    logic [1:0]  bus = 2'h0, size = 2'h0;
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, tgt_addr, tgt_wdata, tgt_rdata;
    logic [31:0] bb_addr, bb_wdata, bb_rdata, r_data;
    logic        bb_req, bb_we, bb_ready, xcs, xwe, xoe, xsync, r_err;
    logic [3:0]  tgt_be, r_be, lat = 4'h0;
    logic [7:0]  r_tgt;
    logic [23:0] xaddr, wr_addr;
    logic [15:0] xdata, xoe_n, xdin, wr_data;
    adb_tgt_t    tgt;
    int          r_cyc, error_cnt = 0, total_checks = 0;

    // 25 ns period
    always #12.5 clk = ~clk;

    adb_fabric adb_fabric_i (.sys_clk_i(clk), .rst_i(rst), .xmem_wide_i(wide), .xmem_sync_i(sync),
        .req_i(req), .bus_sel_i(bus), .fetch_i(fetch), .we_i(we), .size_i(size), .addr_i(addr),
        .wdata_i(wdata), .ready_o(ready), .err_o(err), .rdata_o(rdata), .tgt_o(tgt),
        .tgt_req_o(tgt_req), .tgt_we_o(tgt_we), .tgt_addr_o(tgt_addr), .tgt_wdata_o(tgt_wdata),
        .tgt_be_o(tgt_be), .tgt_ready_i(tgt_ready), .tgt_rdata_i(tgt_rdata), .bb_req_o(bb_req),
        .bb_we_o(bb_we), .bb_addr_o(bb_addr), .bb_wdata_o(bb_wdata), .bb_ready_i(bb_ready),
        .bb_rdata_i(bb_rdata), .xaddr_o(xaddr), .xdata_o(xdata), .xdata_oe_n_o(xoe_n),
        .xdata_i(xdin), .xcs_o(xcs), .xwe_o(xwe), .xoe_o(xoe), .xsync_o(xsync));

    adb_mem_model adb_mem_model_i (.sys_clk_i(clk), .rst_i(rst), .lat_i(lat), .tgt_req_i(tgt_req),
        .tgt_addr_i(tgt_addr), .tgt_ready_o(tgt_ready), .tgt_rdata_o(tgt_rdata), .bb_req_i(bb_req),
        .bb_we_i(bb_we), .bb_addr_i(bb_addr), .bb_wdata_i(bb_wdata), .bb_ready_o(bb_ready),
        .bb_rdata_o(bb_rdata), .xaddr_i(xaddr), .xdata_i(xdata), .xcs_i(xcs), .xwe_i(xwe),
        .xoe_i(xoe), .xdata_o(xdin), .wr_addr_o(wr_addr), .wr_data_o(wr_data));

    task automatic end_sim();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // reset for two cycles; width and memory kind only change here since they must stay static
    task automatic do_reset(input logic w, input logic s);
        wide <= w;
        sync <= s;
        req  <= 1'b0;
        rst  <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask

    // one request, entered just after an edge; leaves req up so the next one can follow back to back
    task automatic acc(input logic [1:0] b, input logic f, input logic w, input logic [1:0] s,
                       input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        bus   <= b;
        fetch <= f;
        we    <= w;
        size  <= s;
        addr  <= a;
        wdata <= d;
        req   <= 1'b1;
        @(negedge clk);
        r_tgt = tgt;
        r_be  = tgt_be;
        while (ready !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        r_cyc  = n;
        r_err  = err;
        r_data = rdata;
        @(posedge clk);
    endtask

    task automatic idle();
        req <= 1'b0;
        @(posedge clk);
    endtask

    task automatic t_ext_wide();
        do_reset(1'b1, 1'b0);
        chk(32'(xsync), 32'h0, "sync pin");
        acc(2'h2, 1'b0, 1'b0, 2'h1, 32'h60123456, 32'h0);
        chk(32'(r_cyc), 32'h4, "ext read cycles");
        chk(32'(r_data[15:0]), 32'h3456 ^ 32'h3C00, "ext read data");
        acc(2'h2, 1'b0, 1'b1, 2'h1, 32'h60ABCDE0, 32'h0000BEEF);
        chk(32'(r_cyc), 32'h4, "ext write cycles");
        chk(32'(wr_addr), 32'h00ABCDE0, "ext write addr");
        chk(32'(wr_data), 32'h0000BEEF, "ext write data");
        acc(2'h2, 1'b1, 1'b0, 2'h2, 32'h60000100, 32'h0);
        chk(32'(r_err), 32'h0, "wide fetch");
        idle();
    endtask

    task automatic t_ext_narrow();
        do_reset(1'b0, 1'b1);
        chk(32'(xsync), 32'h1, "sync pin");
        acc(2'h2, 1'b0, 1'b0, 2'h0, 32'h60000042, 32'h0);
        chk(32'(r_cyc), 32'h4, "narrow cycles");
        chk(32'(r_data[7:0]), 32'h42, "narrow data");
        acc(2'h2, 1'b1, 1'b0, 2'h2, 32'h60000040, 32'h0);
        chk(32'(r_err), 32'h1, "narrow fetch");
        idle();
        do_reset(1'b1, 1'b0);
    endtask

    task automatic t_alias();
        acc(2'h2, 1'b0, 1'b1, 2'h2, 32'h2200000C, 32'h00000001);
        idle();
        chk(adb_mem_model_i.sram_r[0], 32'hC3C3C3E9, "bit set");
        acc(2'h2, 1'b0, 1'b1, 2'h2, 32'h22000014, 32'hFFFFFFFE);
        idle();
        chk(adb_mem_model_i.sram_r[0], 32'hC3C3C3C9, "bit clear");
        acc(2'h2, 1'b0, 1'b0, 2'h2, 32'h2200000C, 32'h0);
        chk(r_data, 32'h1, "alias read one");
        acc(2'h2, 1'b0, 1'b0, 2'h2, 32'h22000084, 32'h0);
        chk(r_data, 32'h0, "alias read zero");
        idle();
    endtask

    // table entries: {bus, fetch, expected target or 00 for refused, address}
    task automatic t_decode();
        logic [47:0] e;
        logic [47:0] tbl [13];
        tbl = '{48'h0_1_02_00000000, 48'h1_0_02_1FFFFFFC, 48'h0_1_00_20000000, 48'h2_0_04_20000100,
                48'h2_1_04_20000100, 48'h2_1_00_40000000, 48'h2_0_08_40000000, 48'h2_0_20_A0000000,
                48'h2_0_80_E0100000, 48'h2_0_00_E000E000, 48'h3_0_40_E000E000, 48'h3_0_00_40000000,
                48'h2_0_00_00001000};
        for (int l = 0; l < 4; l += 3) begin
            lat <= 4'(l);
            for (int i = 0; i < 13; i++) begin
                e = tbl[i];
                acc(e[45:44], e[40], 1'b0, 2'h2, e[31:0], 32'h0);
                chk(32'(r_err), 32'(e[39:32] == 8'h00), "refusal");
                if (e[39:32] != 8'h00) begin
                    chk(32'(r_tgt), 32'(e[39:32]), "target select");
                    chk(r_data, ~e[31:0], "target data");
                end
            end
        end
        acc(2'h2, 1'b0, 1'b0, 2'h2, 32'h40000001, 32'h0);
        chk(32'(r_be), 32'hE, "unaligned word lanes");
        acc(2'h2, 1'b0, 1'b1, 2'h1, 32'h40000001, 32'h0);
        chk(32'(r_be), 32'h6, "unaligned half lanes");
        chk(32'(r_err), 32'h0, "unaligned accepted");
        idle();
    endtask

    // watchdog well beyond the roughly 125 cycles the scenarios need
    initial begin
        #(25 * 4000);
        error_cnt++;
        end_sim();
    end

    initial begin
        t_ext_wide();
        t_ext_narrow();
        t_alias();
        t_decode();
        end_sim();
    end
endmodule

// [verification/adb_mem_model.sv]
/*
 * far-side model: plain target responder, small sram behind the alias engine,
 * and an external memory on the port pins.
 * assumes the fabric holds each request until the matching ready is seen.
 */
`timescale 1ns/1ps
module adb_mem_model (
    // clock, reset and answer latency
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  lat_i,
    // plain targets
    input  wire logic        tgt_req_i,
    input  wire logic [31:0] tgt_addr_i,
    output logic             tgt_ready_o,
    output logic [31:0]      tgt_rdata_o,
    // sram port of the alias engine
    input  wire logic        bb_req_i,
    input  wire logic        bb_we_i,
    input  wire logic [31:0] bb_addr_i,
    input  wire logic [31:0] bb_wdata_i,
    output logic             bb_ready_o,
    output logic [31:0]      bb_rdata_o,
    // external memory pins and last write seen
    input  wire logic [23:0] xaddr_i,
    input  wire logic [15:0] xdata_i,
    input  wire logic        xcs_i,
    input  wire logic        xwe_i,
    input  wire logic        xoe_i,
    output logic [15:0]      xdata_o,
    output logic [23:0]      wr_addr_o,
    output logic [15:0]      wr_data_o
);
    logic [3:0]  cnt_r;
    logic [31:0] sram_r [8];
    logic [15:0] xlast_r;

    // answer after lat_i plus one waiting cycles, so both prompt and slow targets occur
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !tgt_req_i || tgt_ready_o) begin
            cnt_r       <= 4'h0;
            tgt_ready_o <= 1'b0;
        end else begin
            cnt_r       <= cnt_r + 4'h1;
            tgt_ready_o <= (cnt_r == lat_i);
        end
    end
    // read data is valid only with ready; otherwise the plain address instead of its inverse
    assign tgt_rdata_o = tgt_ready_o ? ~tgt_addr_i : tgt_addr_i;

    // sram words start from a known mixed pattern so untouched bits are visible
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            bb_ready_o <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                sram_r[i] <= 32'hC3C3C3E1;
            end
        end else begin
            bb_ready_o <= bb_req_i && !bb_ready_o;
            if (bb_req_i && bb_ready_o && bb_we_i) begin
                sram_r[bb_addr_i[4:2]] <= bb_wdata_i;
            end
        end
    end
    assign bb_rdata_o = bb_ready_o ? sram_r[bb_addr_i[4:2]] : ~sram_r[bb_addr_i[4:2]];

    // external memory drives only while selected and enabled, else inverse of last value
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            xlast_r <= 16'h0000;
        end else if (xcs_i && xoe_i) begin
            xlast_r <= xaddr_i[15:0] ^ 16'h3C00;
        end
        if (xcs_i && xwe_i) begin
            wr_addr_o <= xaddr_i;
            wr_data_o <= xdata_i;
        end
    end
    assign xdata_o = (xcs_i && xoe_i) ? (xaddr_i[15:0] ^ 16'h3C00) : ~xlast_r;
endmodule
